/* hdl/cpmc_pkg.sv */
// cpmc_pkg: constants for the clock and power mode control block
// assumes: shared by the control block and its wake timer
package cpmc_pkg;
    // register offsets, low six bits of the i/o address
    localparam logic [5:0] CPMC_OFF_DOUBLER = 6'h1e;
    localparam logic [5:0] CPMC_OFF_CONTROL = 6'h1f;
    localparam int         CPMC_ADDR_BITS   = 6;
    // field positions
    localparam int CPMC_BIT_DOUBLER   = 7;
    localparam int CPMC_BIT_DIVIDE    = 7;
    localparam int CPMC_BIT_MODE_HI   = 6;
    localparam int CPMC_BIT_BR_WAKE   = 5;
    localparam int CPMC_BIT_LD_CLK    = 4;
    localparam int CPMC_BIT_MODE_LO   = 3;
    localparam int CPMC_BIT_LD_IO     = 2;
    localparam int CPMC_BIT_LD_CTL    = 1;
    localparam int CPMC_BIT_LD_ADDR   = 0;
    // reset values
    localparam logic [7:0] CPMC_RST_DOUBLER = 8'h00;
    localparam logic [7:0] CPMC_RST_CONTROL = 8'h00;
    localparam logic [6:0] CPMC_DOUBLER_RSVD = 7'h7f;
    // power-down modes, {bit6, bit3}
    localparam logic [1:0] CPMC_MODE_NONE    = 2'h0;
    localparam logic [1:0] CPMC_MODE_IDLE    = 2'h1;
    localparam logic [1:0] CPMC_MODE_STANDBY = 2'h2;
    localparam logic [1:0] CPMC_MODE_QUICK   = 2'h3;
    // wake wait counts in clocks
    localparam int CPMC_WAIT_W        = 18;
    localparam int CPMC_STANDBY_WAIT  = 131072;
    localparam int CPMC_QUICK_WAIT    = 64;
    localparam int CPMC_IDLE_WAIT     = 8;
    typedef enum logic [1:0] {CPMC_RUN, CPMC_SLEEP, CPMC_WAKE} cpmc_state_t;
endpackage : cpmc_pkg

/* hdl/cpmc_wake_timer.sv */
// cpmc_wake_timer: loadable down counter for the wake-up wait
// assumes: load and count come from the control block on one clock
`timescale 1ns/1ps
`default_nettype none
module cpmc_wake_timer (
    // clock and reset
    input  wire logic                           clock,
    input  wire logic                           sys_rst,
    // control
    input  wire logic                           load,
    input  wire logic [cpmc_pkg::CPMC_WAIT_W-1:0] load_value,
    // status
    output logic                                done
);
    logic [cpmc_pkg::CPMC_WAIT_W-1:0] count_q;  // remaining clocks
    logic                             busy_q;   // counting

    // count down from the loaded figure, done pulses once at one
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_q <= '0;
            busy_q  <= 1'b0;
            done    <= 1'b0;
        end else if (load) begin
            count_q <= load_value;
            busy_q  <= 1'b1;
            done    <= 1'b0;
        end else if (busy_q) begin
            count_q <= count_q - 1'b1;
            done    <= (count_q == {{(cpmc_pkg::CPMC_WAIT_W-1){1'b0}}, 1'b1});
            busy_q  <= (count_q != {{(cpmc_pkg::CPMC_WAIT_W-1){1'b0}}, 1'b1});
        end else begin
            done    <= 1'b0;
        end
    end
endmodule : cpmc_wake_timer
`default_nettype wire

/* hdl/cpmc_top.sv */
// cpmc_top: clock doubler and cpu clock/power control registers
// assumes: cpu drives i/o strobes on this clock; exit events are pins
`timescale 1ns/1ps
`default_nettype none
module cpmc_top #(
    parameter int STANDBY_WAIT = cpmc_pkg::CPMC_STANDBY_WAIT  // shorten in simulation
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // internal i/o cycle
    input  wire logic [7:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    // sleep handshake
    input  wire logic       sleep_exec,
    input  wire logic       io_stop_bit,
    input  wire logic       exit_event,
    input  wire logic       bus_request_in,
    // clocking outputs
    output logic            cpu_clock_en,
    output logic            system_clock_output,
    output logic            oscillator_run,
    output logic            controls_active,
    output logic            clock_doubler_enable,
    // drive strength outputs
    output logic            low_drive_clock_out,
    output logic            low_drive_io_pins,
    output logic            low_drive_cpu_controls,
    output logic            low_drive_addr_data
);
    logic [7:0]  doubler_q;       // doubler control register
    logic [7:0]  control_q;       // cpu clock and power control
    logic        sel_doubler;     // address hits doubler register
    logic        sel_control;     // address hits control register
    logic        exit_s1_q;       // synchroniser, first stage
    logic        exit_s2_q;       // synchroniser, second stage
    logic        breq_s1_q;
    logic        breq_s2_q;
    logic        divide_q;        // divide setting in force
    logic        doubler_act_q;   // doubler setting in force
    logic        div_tgl_q;       // xtal/2 phase
    logic        tick;            // one cpu clock enable
    logic [1:0]  mode;            // current sleep mode field
    logic        wake;            // an exit condition is present
    logic        timer_load;
    logic [cpmc_pkg::CPMC_WAIT_W-1:0] timer_value;
    logic        timer_done;
    cpmc_pkg::cpmc_state_t state_q;

    function automatic logic hit(input logic [7:0] a, input logic [5:0] off);
        hit = (a[cpmc_pkg::CPMC_ADDR_BITS-1:0] == off);
    endfunction : hit

    assign sel_doubler = hit(io_addr, cpmc_pkg::CPMC_OFF_DOUBLER);
    assign sel_control = hit(io_addr, cpmc_pkg::CPMC_OFF_CONTROL);
    assign mode = {control_q[cpmc_pkg::CPMC_BIT_MODE_HI], control_q[cpmc_pkg::CPMC_BIT_MODE_LO]};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            doubler_q <= cpmc_pkg::CPMC_RST_DOUBLER;
        end else if (io_wr && sel_doubler) begin
            doubler_q <= {io_wdata[cpmc_pkg::CPMC_BIT_DOUBLER], 7'h00};
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            control_q <= cpmc_pkg::CPMC_RST_CONTROL;
        end else if (io_wr && sel_control) begin
            control_q <= io_wdata;
        end
    end

    // read data registered; reserved doubler bits read as ones
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            io_rdata <= 8'h00;
        end else if (io_rd && sel_doubler) begin
            io_rdata <= {doubler_q[cpmc_pkg::CPMC_BIT_DOUBLER], cpmc_pkg::CPMC_DOUBLER_RSVD};
        end else if (io_rd && sel_control) begin
            io_rdata <= control_q;
        end else begin
            io_rdata <= 8'h00;  // other offsets belong elsewhere
        end
    end

    // pin inputs pass two flops before use
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            exit_s1_q <= 1'b0;
            exit_s2_q <= 1'b0;
            breq_s1_q <= 1'b0;
            breq_s2_q <= 1'b0;
        end else begin
            exit_s1_q <= exit_event;
            exit_s2_q <= exit_s1_q;
            breq_s1_q <= bus_request_in;
            breq_s2_q <= breq_s1_q;
        end
    end

    // bus request wakes only when enabled
    assign wake = exit_s2_q || (breq_s2_q && control_q[cpmc_pkg::CPMC_BIT_BR_WAKE]);

    // settings change only at a phase boundary
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            divide_q      <= 1'b0;
            doubler_act_q <= 1'b0;
            div_tgl_q     <= 1'b0;
        end else begin
            div_tgl_q <= ~div_tgl_q;
            // swapping mid-phase would cut a half period short
            if (div_tgl_q) begin
                divide_q      <= control_q[cpmc_pkg::CPMC_BIT_DIVIDE];
                doubler_act_q <= doubler_q[cpmc_pkg::CPMC_BIT_DOUBLER];
            end
        end
    end

    // xtal/2 gives every other tick, xtal/1 every tick
    assign tick = divide_q || doubler_act_q || div_tgl_q;

    // sleep entry per mode; cpu must have set io stop
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= cpmc_pkg::CPMC_RUN;
        end else begin
            case (state_q)
                cpmc_pkg::CPMC_RUN: begin
                    if (sleep_exec && io_stop_bit && mode != cpmc_pkg::CPMC_MODE_NONE) begin
                        state_q <= cpmc_pkg::CPMC_SLEEP;
                    end
                end
                cpmc_pkg::CPMC_SLEEP: begin
                    if (wake) begin
                        state_q <= cpmc_pkg::CPMC_WAKE;
                    end
                end
                cpmc_pkg::CPMC_WAKE: begin
                    if (timer_done) begin
                        state_q <= cpmc_pkg::CPMC_RUN;
                    end
                end
                default: state_q <= cpmc_pkg::CPMC_RUN;
            endcase
        end
    end

    always_comb begin
        timer_load = (state_q == cpmc_pkg::CPMC_SLEEP) && wake;
        case (mode)
            cpmc_pkg::CPMC_MODE_IDLE:  timer_value = cpmc_pkg::CPMC_WAIT_W'(cpmc_pkg::CPMC_IDLE_WAIT);
            cpmc_pkg::CPMC_MODE_QUICK: timer_value = cpmc_pkg::CPMC_WAIT_W'(cpmc_pkg::CPMC_QUICK_WAIT);
            default:                   timer_value = cpmc_pkg::CPMC_WAIT_W'(STANDBY_WAIT);
        endcase
    end

    cpmc_wake_timer u_timer (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .load       (timer_load),
        .load_value (timer_value),
        .done       (timer_done)
    );

    // clocks stop while asleep; oscillator stops in standby and quick modes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cpu_clock_en         <= 1'b0;
            system_clock_output  <= 1'b0;
            oscillator_run       <= 1'b1;
            controls_active      <= 1'b1;
            clock_doubler_enable <= 1'b0;
        end else begin
            cpu_clock_en         <= (state_q == cpmc_pkg::CPMC_RUN) && tick;
            // toggles each tick, so high and low phases stay whole
            if (state_q == cpmc_pkg::CPMC_RUN && tick) begin
                system_clock_output <= ~system_clock_output;
            end
            // oscillator off while standby or quick sleeps
            // the wake wait is its settling time, so it must run then
            oscillator_run       <= (state_q != cpmc_pkg::CPMC_SLEEP) || (mode == cpmc_pkg::CPMC_MODE_IDLE);
            controls_active      <= (state_q == cpmc_pkg::CPMC_RUN);
            clock_doubler_enable <= doubler_act_q;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            low_drive_clock_out    <= 1'b0;
            low_drive_io_pins      <= 1'b0;
            low_drive_cpu_controls <= 1'b0;
            low_drive_addr_data    <= 1'b0;
        end else begin
            low_drive_clock_out    <= control_q[cpmc_pkg::CPMC_BIT_LD_CLK];
            low_drive_io_pins      <= control_q[cpmc_pkg::CPMC_BIT_LD_IO];
            low_drive_cpu_controls <= control_q[cpmc_pkg::CPMC_BIT_LD_CTL];
            low_drive_addr_data    <= control_q[cpmc_pkg::CPMC_BIT_LD_ADDR];
        end
    end
endmodule : cpmc_top
`default_nettype wire

/* verif/cpmc_top_monitor.sv */
// cpmc_top_monitor: port checks for the clock and power control block
// assumes: bound into cpmc_top; one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module cpmc_top_monitor (
    // clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // i/o cycle
    input wire logic [7:0] io_addr,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic       sleep_exec,
    input wire logic       io_stop_bit,
    // watched outputs
    input wire logic       cpu_clock_en,
    input wire logic       oscillator_run,
    input wire logic       controls_active,
    input wire logic       clock_doubler_enable,
    input wire logic       low_drive_clock_out,
    input wire logic       low_drive_io_pins,
    input wire logic       low_drive_cpu_controls,
    input wire logic       low_drive_addr_data
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // upper address bits are ignored, so decode six
    wire logic       hit_dbl = io_addr[5:0] == 6'h1e;
    wire logic       hit_ctl = io_addr[5:0] == 6'h1f;
    // drive bits laid out as in the control byte
    wire logic [7:0] drv     = {3'h0, low_drive_clock_out, 1'b0, low_drive_io_pins,
                                low_drive_cpu_controls, low_drive_addr_data};
    a_unmapped_reads_zero: assert property (io_rd && !hit_dbl && !hit_ctl |=> io_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_doubler_rsvd_ones: assert property (io_rd && hit_dbl |=> io_rdata[6:0] == 7'h7f)
        else $error("doubler reserved bits not ones");
    // wait one quiet cycle so a copy stage may lag
    a_drive_bits_follow: assert property (io_wr && hit_ctl ##1 !io_wr |=> drv == ($past(io_wdata, 2) & 8'h17))
        else $error("drive outputs differ from written bits");
    a_ctl_read_back: assert property (io_rd && hit_ctl && !io_wr && !$past(io_wr) |=> (io_rdata & 8'h17) == drv)
        else $error("control readback differs from drive bits");
    // in force within two cycles, output one cycle later
    a_doubler_in_force: assert property (io_wr && hit_dbl && io_wdata[7] ##1 !io_wr [*3] |=> clock_doubler_enable)
        else $error("doubler not in force");
    a_sleep_entry_cause: assert property ($fell(controls_active) |->
        $past(sleep_exec, 2) && $past(io_stop_bit, 2) && !cpu_clock_en)
        else $error("controls dropped without sleep request");
    a_wake_min_wait: assert property ($fell(controls_active) |-> !controls_active [*8])
        else $error("controls back too soon");
    a_wake_osc_on: assert property ($rose(controls_active) |-> oscillator_run)
        else $error("controls back with oscillator stopped");
    // oscillator restarts for its settling wait, before controls return
    a_osc_before_ctl: assert property ($rose(oscillator_run) |-> !controls_active)
        else $error("oscillator restarted with controls already active");
    c_doubler_read: cover property (io_rd && hit_dbl);
    c_wake_seen: cover property ($rose(controls_active));
    c_standby_write: cover property (io_wr && hit_ctl && io_wdata[6]);
endmodule : cpmc_top_monitor
bind cpmc_top cpmc_top_monitor u_mon (.clock(clock), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .sleep_exec(sleep_exec), .io_stop_bit(io_stop_bit),
    .cpu_clock_en(cpu_clock_en), .oscillator_run(oscillator_run), .controls_active(controls_active),
    .clock_doubler_enable(clock_doubler_enable), .low_drive_clock_out(low_drive_clock_out),
    .low_drive_io_pins(low_drive_io_pins), .low_drive_cpu_controls(low_drive_cpu_controls),
    .low_drive_addr_data(low_drive_addr_data));
`default_nettype wire

/* verif/testbench.sv */
// testbench: register, tick and sleep checks of cpmc_top
// assumes: design compiled first; standby wait shortened to 16
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clock = 0, sys_rst = 1, io_wr = 0, io_rd = 0, sleep_exec = 0, rd_seen = 0;
    logic       io_stop_bit = 0, exit_event = 0, bus_request_in = 0;
    logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, v;
    logic       cpu_clock_en, clk_out, osc, ctl_act, dbl, ld_clk, ld_io, ld_ctl, ld_ad;
    int         errors = 0, n_tests = 0, cnt;
    logic [7:0] exp_q[$];  // expected read answers, oldest first
    always #50 clock = ~clock;
    cpmc_top #(.STANDBY_WAIT(16)) u_cpmc_top (.clock(clock), .sys_rst(sys_rst), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .sleep_exec(sleep_exec),
        .io_stop_bit(io_stop_bit), .exit_event(exit_event), .bus_request_in(bus_request_in),
        .cpu_clock_en(cpu_clock_en), .system_clock_output(clk_out), .oscillator_run(osc),
        .controls_active(ctl_act), .clock_doubler_enable(dbl), .low_drive_clock_out(ld_clk),
        .low_drive_io_pins(ld_io), .low_drive_cpu_controls(ld_ctl), .low_drive_addr_data(ld_ad));
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        if (errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    // answer watcher: read data lands one cycle after the read edge
    always @(posedge clock) begin
        if (rd_seen) check("io_rdata", io_rdata, exp_q.pop_front());
        rd_seen <= io_rd;
    end
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        #1 io_wr = 1;
        io_addr = a;
        io_wdata = d;
        @(posedge clock);
        #1 io_wr = 0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clock);
        #1 io_rd = 1;
        io_addr = a;
        exp_q.push_back(e);
        @(posedge clock);
        #1 io_rd = 0;
    endtask : rd
    // tick rate: half the cycles at xtal/2, all when undivided
    task automatic ticks(logic [7:0] e);
        logic p;  // clock output at the previous sample
        int   t;  // clock output toggles seen
        cnt = 0;
        t = 0;
        @(posedge clock);
        p = clk_out;
        repeat (20) begin
            @(posedge clock);
            cnt += cpu_clock_en;
            t += int'(clk_out !== p);
            p = clk_out;
        end
        check("tick_count", 8'(cnt), e);
        check("clock_out_toggles", 8'(t), e);
    endtask : ticks
    // sleep in mode m; bus request first, which only wakes with bit 5
    task automatic nap(logic [7:0] m, int w, logic o);
        wr(8'h1f, m);
        @(posedge clock);
        #1 io_stop_bit = 1;
        sleep_exec = 1;
        @(posedge clock);
        #1 sleep_exec = 0;
        repeat (3) @(posedge clock);
        check("asleep", {6'h0, osc, ctl_act}, {6'h0, o, ~(m[6] | m[3])});
        #1 bus_request_in = 1;
        if (!m[5]) begin
            repeat (30) @(posedge clock);
            check("br_ignored", {7'h0, ctl_act}, {7'h0, ~(m[6] | m[3])});
            #1 bus_request_in = 0;
            exit_event = 1;
        end
        cnt = 0;
        while (ctl_act !== 1'b1 && cnt < 300) begin
            @(posedge clock);
            cnt++;
        end
        check("wake_wait", 8'(cnt >= w && cnt <= w + 6), 8'h01);
        #1 bus_request_in = 0;
        exit_event = 0;
        io_stop_bit = 0;
    endtask : nap
    // watchdog: whole run needs well under 5000 cycles
    initial begin
        #500000;
        errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(20922));
        repeat (20) @(posedge clock);
        #1 sys_rst = 0;
        rd(8'h1e, 8'h7f);
        rd(8'h1f, 8'h00);
        rd(8'h2a, 8'h00);
        ticks(8'd10);
        wr(8'hde, 8'h80);
        rd(8'h5e, 8'hff);
        // setting in force within two cycles, output one more
        repeat (2) @(posedge clock);
        check("doubler", {7'h0, dbl}, 8'h01);
        ticks(8'd20);
        wr(8'h1e, 8'h00);
        wr(8'h9f, 8'h80);
        rd(8'h1f, 8'h80);
        ticks(8'd20);
        repeat (8) begin
            v = 8'($urandom);
            wr({2'($urandom), 6'h1f}, v);
            // drive copies land one cycle after the write edge
            repeat (2) @(posedge clock);
            check("low_drive", {3'h0, ld_clk, 1'b0, ld_io, ld_ctl, ld_ad}, v & 8'h17);
            rd({2'($urandom), 6'h1f}, v);
        end
        nap(8'h00, 0, 1);
        nap(8'h08, 8, 1);
        nap(8'h40, 16, 0);
        nap(8'h48, 64, 0);
        nap(8'h28, 8, 1);
        repeat (3) @(posedge clock);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
